//--- common/msct_pkg.sv
// Shared constants for the stripe clock-and-data transmitter.
// Assumes a 10 MHz system clock; all cycle counts derive from it.
`default_nettype none

package msct_pkg;

	// System clock rate
	localparam int SYS_CLK_KHZ = 10_000;

	// Bit cell timing, in microseconds as specified
	localparam int CELL_US = 660;
	localparam int LOW_US = 220;
	localparam int HIGH_US = 440;

	// Cycle counts; the cell and the low phase both come out exact
	localparam int CELL_CYC = (CELL_US * SYS_CLK_KHZ) / 1000;
	localparam int LOW_CYC = (LOW_US * SYS_CLK_KHZ) / 1000;
	localparam int CNT_W = 13;

	// Hold time against repeated identification of one tag
	localparam int HOLD_MS = 1000;
	localparam int HOLD_CYC = HOLD_MS * SYS_CLK_KHZ;
	localparam int HOLD_W = 24;

	// Idle clock pulses before and after the characters
	localparam int AMBLE_PULSES = 16;
	localparam int AMBLE_W = 4;
	localparam logic [AMBLE_W-1:0] AMBLE_LAST = 4'hF;

	// Character codes and bits per character
	localparam logic [3:0] CODE_START = 4'hB;
	localparam logic [3:0] CODE_END = 4'hF;
	localparam logic [3:0] CODE_MAX_DIGIT = 4'h9;
	localparam int CHAR_BITS = 5;
	localparam logic [2:0] LAST_BIT_IDX = 3'h4;

	// Digit queue shape
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 5;

	// Sequencer phases
	typedef enum logic [2:0] {
		MSCT_IDLE,
		MSCT_DROP,
		MSCT_PRE,
		MSCT_CHAR,
		MSCT_POST,
		MSCT_FINISH
	} msct_phase_t;

	// Kind of character on the line
	typedef enum logic [1:0] {
		MSCT_K_START,
		MSCT_K_DATA,
		MSCT_K_END,
		MSCT_K_LRC
	} msct_kind_t;

endpackage

`default_nettype wire

//--- hdl/msct_fifo.sv
// Small synchronous FIFO holding queued digits.
// Assumes writer and reader share sys_clk; valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module msct_fifo #(
	parameter int WIDTH = msct_pkg::FIFO_WIDTH,
	parameter int DEPTH = msct_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} msct_fifo_state_t;

	msct_fifo_state_t r;
	msct_fifo_state_t next_r;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty
	assign empty = (r.wr_ptr == r.rd_ptr);
	assign full = (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]) && (r.wr_ptr[AW] != r.rd_ptr[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = r.mem[r.rd_ptr[AW-1:0]];

	// Pointer and storage update
	always_comb begin
		next_r = r;
		if (in_valid && !full) begin
			next_r.mem[r.wr_ptr[AW-1:0]] = in_data;
			next_r.wr_ptr = r.wr_ptr + 1'b1;
		end
		if (out_ready && !empty) begin
			next_r.rd_ptr = r.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

endmodule

`default_nettype wire

//--- hdl/msct_char_enc.sv
// Character encoder: four code bits plus an odd parity bit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module msct_char_enc (
	input wire logic [3:0] code,
	output logic [msct_pkg::CHAR_BITS-1:0] frame
);

	// Bit 0 leaves first, parity sits in bit 4 and leaves last
	assign frame = {~(^code), code};

endmodule

`default_nettype wire

//--- hdl/msct_transmitter.sv
// Stripe clock-and-data transmitter: frames one identification into
// preamble, start sentinel, digits, end sentinel, check character, postamble.
// Assumes digits are queued before or while the preamble runs and that
// an identification is offered only while ident_ready is high.
`timescale 1ns/1ps
`default_nettype none

module msct_transmitter #(
	parameter int TAG_W = 32,
	parameter int CELL_CYCLES = msct_pkg::CELL_CYC,
	parameter int LOW_CYCLES = msct_pkg::LOW_CYC,
	parameter int HOLD_CYCLES = msct_pkg::HOLD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ident_valid,
	output logic ident_ready,
	input wire logic [TAG_W-1:0] ident_tag,
	input wire logic digit_valid,
	output logic digit_ready,
	input wire logic [3:0] digit_code,
	input wire logic digit_last,
	output logic strobe_clock_out,
	output logic serial_data_out,
	output logic card_present_out_n,
	output logic busy
);

	localparam logic [msct_pkg::CNT_W-1:0] CELL_END = msct_pkg::CNT_W'(CELL_CYCLES - 1);
	localparam logic [msct_pkg::CNT_W-1:0] RISE_AT = msct_pkg::CNT_W'(LOW_CYCLES);
	localparam logic [msct_pkg::HOLD_W-1:0] HOLD_LOAD = msct_pkg::HOLD_W'(HOLD_CYCLES);

	typedef struct packed {
		msct_pkg::msct_phase_t phase;
		msct_pkg::msct_kind_t kind;
		logic [msct_pkg::CNT_W-1:0] cnt;
		logic [msct_pkg::AMBLE_W-1:0] cells;
		logic [2:0] bit_idx;
		logic [msct_pkg::CHAR_BITS-1:0] frame;
		logic [3:0] lrc;
		logic last_seen;
		logic strobe;
		logic data;
		logic card_n;
		logic tag_known;
		logic [TAG_W-1:0] last_tag;
		logic [msct_pkg::HOLD_W-1:0] hold_cnt;
	} msct_state_t;

	msct_state_t r;
	msct_state_t next_r;

	// Queue side signals
	logic q_valid;
	logic q_pop;
	logic [msct_pkg::FIFO_WIDTH-1:0] q_data;
	logic [3:0] q_code;
	logic q_last;
	logic q_digit_ok;

	// Encoder side signals
	logic [3:0] enc_code;
	logic [msct_pkg::CHAR_BITS-1:0] enc_frame;

	// Sequencing helpers
	logic active;
	logic at_rise;
	logic at_end;
	logic hold_running;
	logic repeat_tag;
	logic need_digit;

	assign q_code = q_data[3:0];
	assign q_last = q_data[4];
	assign q_digit_ok = (q_code <= msct_pkg::CODE_MAX_DIGIT);

	// Digits buffered ahead of the bit sequencer
	msct_fifo #(
		.WIDTH(msct_pkg::FIFO_WIDTH),
		.DEPTH(msct_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(digit_valid),
		.in_ready(digit_ready),
		.in_data({digit_last, digit_code}),
		.out_valid(q_valid),
		.out_ready(q_pop),
		.out_data(q_data)
	);

	// Next character code picked from where the message stands
	always_comb begin
		enc_code = msct_pkg::CODE_START;
		if (r.phase == msct_pkg::MSCT_CHAR) begin
			if (r.kind == msct_pkg::MSCT_K_END) begin
				enc_code = r.lrc;
			end else if (r.last_seen) begin
				enc_code = msct_pkg::CODE_END;
			end else begin
				enc_code = q_code;
			end
		end
	end

	msct_char_enc u_enc (
		.code(enc_code),
		.frame(enc_frame)
	);

	// Cell position decode
	assign active = (r.phase == msct_pkg::MSCT_PRE) || (r.phase == msct_pkg::MSCT_CHAR) ||
		(r.phase == msct_pkg::MSCT_POST) || (r.phase == msct_pkg::MSCT_FINISH);
	assign at_rise = active && (r.cnt == RISE_AT);
	assign at_end = active && (r.cnt == CELL_END);

	// Repeat filter against one tag seen twice in quick succession
	assign hold_running = (r.hold_cnt != '0);
	assign repeat_tag = r.tag_known && hold_running && (ident_tag == r.last_tag);

	// A digit is wanted when a start or data character has just ended
	assign need_digit = at_rise && (r.phase == msct_pkg::MSCT_CHAR) &&
		(r.bit_idx == msct_pkg::LAST_BIT_IDX) && !r.last_seen &&
		((r.kind == msct_pkg::MSCT_K_START) || (r.kind == msct_pkg::MSCT_K_DATA));

	// Pop while flushing a refused message, or when the next digit is due
	assign q_pop = q_valid && ((r.phase == msct_pkg::MSCT_DROP) || need_digit);

	assign ident_ready = (r.phase == msct_pkg::MSCT_IDLE);

	// Whole sequencer: phases, cell counter, bit loader, check sum
	always_comb begin
		next_r = r;

		// Hold timer runs down on its own
		if (hold_running) begin
			next_r.hold_cnt = r.hold_cnt - 1'b1;
		end

		// Cell counter runs only while sending; a stall parks it at the rise.
		// A skipped code also parks it, so it never adds a cell to the line.
		if (active) begin
			if (at_end) begin
				next_r.cnt = '0;
			end else if (!(need_digit && !(q_valid && q_digit_ok))) begin
				next_r.cnt = r.cnt + 1'b1;
			end
		end

		unique case (r.phase)
			msct_pkg::MSCT_IDLE: begin
				next_r.data = 1'b0;
				if (ident_valid) begin
					if (repeat_tag) begin
						next_r.phase = msct_pkg::MSCT_DROP;
					end else begin
						// Accepted: start the preamble, restart the hold window
						next_r.phase = msct_pkg::MSCT_PRE;
						next_r.cnt = '0;
						next_r.cells = '0;
						next_r.last_seen = 1'b0;
						next_r.tag_known = 1'b1;
						next_r.last_tag = ident_tag;
						next_r.hold_cnt = HOLD_LOAD;
						next_r.card_n = 1'b0;
					end
				end
			end

			msct_pkg::MSCT_DROP: begin
				// Digits of a refused event are discarded, never sent
				if (q_valid && q_last) begin
					next_r.phase = msct_pkg::MSCT_IDLE;
				end
			end

			msct_pkg::MSCT_PRE: begin
				if (at_rise) begin
					if (r.cells != msct_pkg::AMBLE_LAST) begin
						next_r.cells = r.cells + 1'b1;
						next_r.data = 1'b0;
					end else begin
						// Start sentinel goes out first
						next_r.phase = msct_pkg::MSCT_CHAR;
						next_r.kind = msct_pkg::MSCT_K_START;
						next_r.frame = enc_frame;
						next_r.bit_idx = '0;
						next_r.data = enc_frame[0];
						next_r.lrc = msct_pkg::CODE_START;
					end
				end
			end

			msct_pkg::MSCT_CHAR: begin
				if (at_rise) begin
					if (r.bit_idx != msct_pkg::LAST_BIT_IDX) begin
						// Next bit loaded after the rise, stable at the next fall
						next_r.bit_idx = r.bit_idx + 1'b1;
						next_r.data = r.frame[r.bit_idx + 3'h1];
					end else begin
						unique case (r.kind)
							msct_pkg::MSCT_K_START,
							msct_pkg::MSCT_K_DATA: begin
								if (r.last_seen) begin
									// Digits exhausted: end sentinel
									next_r.kind = msct_pkg::MSCT_K_END;
									next_r.frame = enc_frame;
									next_r.bit_idx = '0;
									next_r.data = enc_frame[0];
									next_r.lrc = r.lrc ^ msct_pkg::CODE_END;
								end else if (q_valid) begin
									next_r.last_seen = q_last;
									if (q_digit_ok) begin
										next_r.kind = msct_pkg::MSCT_K_DATA;
										next_r.frame = enc_frame;
										next_r.bit_idx = '0;
										next_r.data = enc_frame[0];
										next_r.lrc = r.lrc ^ q_code;
									end
									// An illegal code is popped and skipped
								end
							end
							msct_pkg::MSCT_K_END: begin
								// Check character closes the message
								next_r.kind = msct_pkg::MSCT_K_LRC;
								next_r.frame = enc_frame;
								next_r.bit_idx = '0;
								next_r.data = enc_frame[0];
							end
							msct_pkg::MSCT_K_LRC: begin
								next_r.phase = msct_pkg::MSCT_POST;
								next_r.cells = '0;
								next_r.data = 1'b0;
							end
						endcase
					end
				end
			end

			msct_pkg::MSCT_POST: begin
				if (at_rise) begin
					next_r.data = 1'b0;
					if (r.cells != msct_pkg::AMBLE_LAST) begin
						next_r.cells = r.cells + 1'b1;
					end else begin
						next_r.phase = msct_pkg::MSCT_FINISH;
					end
				end
			end

			msct_pkg::MSCT_FINISH: begin
				// Release only after the last postamble cell is complete
				if (at_end) begin
					next_r.phase = msct_pkg::MSCT_IDLE;
					next_r.card_n = 1'b1;
				end
			end

			default: begin
				next_r.phase = msct_pkg::MSCT_IDLE;
			end
		endcase

		// Strobe low for the first part of each cell, high otherwise
		next_r.strobe = !(((next_r.phase == msct_pkg::MSCT_PRE) ||
			(next_r.phase == msct_pkg::MSCT_CHAR) ||
			(next_r.phase == msct_pkg::MSCT_POST) ||
			(next_r.phase == msct_pkg::MSCT_FINISH)) &&
			(next_r.cnt < RISE_AT));
	end

	// Single state register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.phase <= msct_pkg::MSCT_IDLE;
			r.kind <= msct_pkg::MSCT_K_START;
			r.strobe <= 1'b1;
			r.card_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Line outputs straight from flip-flops
	assign strobe_clock_out = r.strobe;
	assign serial_data_out = r.data;
	assign card_present_out_n = r.card_n;
	assign busy = (r.phase != msct_pkg::MSCT_IDLE);

endmodule

`default_nettype wire

//--- dv/msct_tx_chk.sv
// Checker for the stripe transmitter's line outputs.
// Bound to msct_transmitter; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module msct_tx_chk #(
	parameter int TAG_W = 32,
	parameter int CELL_CYCLES = 6600,
	parameter int LOW_CYCLES = 2200,
	parameter int HOLD_CYCLES = 10_000_000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ident_valid,
	input wire logic ident_ready,
	input wire logic [TAG_W-1:0] ident_tag,
	input wire logic digit_valid,
	input wire logic digit_ready,
	input wire logic [3:0] digit_code,
	input wire logic digit_last,
	input wire logic strobe_clock_out,
	input wire logic serial_data_out,
	input wire logic card_present_out_n,
	input wire logic busy
);
	logic prev_strobe;
	int low_cnt;
	int high_cnt;
	int falls;

	// Phase lengths and falling edges per frame; long counts kept out of repetitions
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_strobe <= 1'h1;
			low_cnt <= 0;
			high_cnt <= 0;
			falls <= 0;
		end else begin
			prev_strobe <= strobe_clock_out;
			low_cnt <= strobe_clock_out ? 0 : low_cnt + 1;
			high_cnt <= strobe_clock_out ? high_cnt + 1 : 0;
			falls <= card_present_out_n ? 0 : falls + int'(prev_strobe && !strobe_clock_out);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_idle_strobe_high: assert property (card_present_out_n |-> strobe_clock_out)
		else $error("strobe low outside a frame");
	a_idle_data_low: assert property (card_present_out_n |-> !serial_data_out)
		else $error("data active outside a frame");
	a_data_at_fall: assert property ($fell(strobe_clock_out) |-> $stable(serial_data_out))
		else $error("data moved at strobe fall");
	a_low_phase_len: assert property ($rose(strobe_clock_out) |-> low_cnt == LOW_CYCLES)
		else $error("strobe low phase wrong length");
	a_cell_len: assert property ($fell(strobe_clock_out) && !$past(card_present_out_n) |->
		high_cnt >= CELL_CYCLES - LOW_CYCLES)
		else $error("bit cell too short");
	a_frame_cells: assert property ($rose(card_present_out_n) |-> falls >= 52 && (falls - 32) % 5 == 0)
		else $error("frame cell count wrong");
	a_start_on_accept: assert property ($fell(card_present_out_n) |->
		$past(ident_valid && ident_ready) && $fell(strobe_clock_out) && busy)
		else $error("frame start without accepted identification");
	a_card_while_busy: assert property (!card_present_out_n |-> busy && !ident_ready)
		else $error("card signal low while idle");

	cover property ($rose(card_present_out_n));
	cover property (ident_valid && !ident_ready);
	cover property (!digit_ready);
endmodule

`default_nettype wire

//--- dv/msct_panel_model.sv
// Reader input of an access panel: samples data on strobe falls.
// Assumes it shares sys_clk with the transmitter; drives nothing.
`timescale 1ns/1ps
`default_nettype none

module msct_panel_model (
	input wire logic sys_clk,
	input wire logic strobe_clock_out,
	input wire logic serial_data_out,
	input wire logic card_present_out_n
);
	logic bits[$];
	int frames = 0;
	logic prev_strobe = 1'h1;
	logic prev_card = 1'h1;

	// New frame clears the capture; one bit per falling strobe edge
	always @(posedge sys_clk) begin
		if (prev_card && !card_present_out_n) begin
			bits.delete();
			frames++;
		end
		if (prev_strobe && !strobe_clock_out && !card_present_out_n)
			bits.push_back(serial_data_out);
		prev_strobe = strobe_clock_out;
		prev_card = card_present_out_n;
	end
endmodule

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the stripe transmitter with shortened cells.
// Assumes the panel model and checker files are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int CELL = 60;
	localparam int LOW = 20;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic ident_valid = 1'h0;
	logic ident_ready;
	logic [31:0] ident_tag = 32'h0000_0000;
	logic digit_valid = 1'h0;
	logic digit_ready;
	logic [3:0] digit_code = 4'h0;
	logic digit_last = 1'h0;
	logic strobe_clock_out;
	logic serial_data_out;
	logic card_present_out_n;
	logic busy;
	int n_fail = 0;
	int comparisons = 0;
	logic exp_q[$];

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	msct_transmitter #(.CELL_CYCLES(CELL), .LOW_CYCLES(LOW), .HOLD_CYCLES(30000)) i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .ident_valid(ident_valid), .ident_ready(ident_ready),
		.ident_tag(ident_tag), .digit_valid(digit_valid), .digit_ready(digit_ready),
		.digit_code(digit_code), .digit_last(digit_last), .strobe_clock_out(strobe_clock_out),
		.serial_data_out(serial_data_out), .card_present_out_n(card_present_out_n), .busy(busy));

	msct_panel_model i_panel (.sys_clk(sys_clk), .strobe_clock_out(strobe_clock_out),
		.serial_data_out(serial_data_out), .card_present_out_n(card_present_out_n));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Code bits low first, then the odd parity bit
	function automatic void add_char(logic [3:0] c);
		for (int i = 0; i < 4; i++)
			exp_q.push_back(c[i]);
		exp_q.push_back(~^c);
	endfunction

	// Valid stays high between digits so it is never lowered and raised in one step
	// Request held until an edge that finds the queue ready
	task automatic push(logic [3:0] c, logic last);
		digit_valid = 1'h1;
		digit_code = c;
		digit_last = last;
		while (digit_ready !== 1'h1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1;
	endtask

	task automatic offer(logic [31:0] tag);
		ident_tag = tag;
		ident_valid = 1'h1;
		@(posedge sys_clk);
		#1;
		ident_valid = 1'h0;
	endtask

	task automatic wait_card(logic lvl, int lim);
		int t;
		t = 0;
		while (card_present_out_n !== lvl && t < lim) begin
			@(posedge sys_clk);
			#1;
			t++;
		end
		chk("card_present_out_n", lvl, card_present_out_n);
	endtask

	// Queue digits, start a frame and compare every captured bit
	task automatic send_msg(logic [31:0] tag, logic [3:0] d[$]);
		logic [3:0] lrc;
		lrc = 4'hB ^ 4'hF;
		exp_q.delete();
		repeat (16) exp_q.push_back(1'h0);
		add_char(4'hB);
		foreach (d[i]) begin
			push(d[i], i == d.size() - 1);
			if (d[i] <= 4'h9) begin
				add_char(d[i]);
				lrc ^= d[i];
			end
		end
		digit_valid = 1'h0;
		add_char(4'hF);
		add_char(lrc);
		repeat (16) exp_q.push_back(1'h0);
		if (d.size() == 8)
			chk("digit_ready full", 1'h0, digit_ready);
		offer(tag);
		wait_card(1'h0, 4);
		@(posedge sys_clk);
		#1;
		offer(tag ^ 32'h0000_FFFF);
		wait_card(1'h1, 90 * CELL);
		chk("bit count", exp_q.size(), i_panel.bits.size());
		foreach (exp_q[i])
			if (i < i_panel.bits.size())
				chk("line bit", exp_q[i], i_panel.bits[i]);
	endtask

	initial begin
		logic [3:0] d[$];
		int n;
		int f;
		void'($urandom(56));
		repeat (2) @(posedge sys_clk);
		#1;
		rst_n = 1'h1;
		// Worked example: six digits give check character 3
		d = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
		send_msg(32'h0000_0101, d);
		$display("test example done");
		// Same tag inside the hold time; its digit must be discarded
		f = i_panel.frames;
		push(4'h7, 1'h1);
		digit_valid = 1'h0;
		offer(32'h0000_0101);
		repeat (100) @(posedge sys_clk);
		#1;
		chk("frames after repeat", f, i_panel.frames);
		chk("card after repeat", 1'h1, card_present_out_n);
		$display("test repeat done");
		// Random lengths with illegal codes among the digits; first one fills the queue
		for (int m = 0; m < 4; m++) begin
			d.delete();
			n = (m == 0) ? 8 : $urandom_range(7, 1);
			for (int k = 0; k < n - 1; k++)
				d.push_back(4'($urandom_range(15, 0)));
			d.push_back(4'($urandom_range(9, 0)));
			send_msg(32'h0000_0200 + m, d);
			$display("test random %0d done", m);
		end
		test_done();
	end

	// Whole run is well under 60k cycles
	initial begin
		#6_000_000;
		n_fail++;
		test_done();
	end
endmodule

bind msct_transmitter msct_tx_chk #(.TAG_W(TAG_W), .CELL_CYCLES(CELL_CYCLES), .LOW_CYCLES(LOW_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ident_valid(ident_valid),
	.ident_ready(ident_ready), .ident_tag(ident_tag), .digit_valid(digit_valid), .digit_ready(digit_ready),
	.digit_code(digit_code), .digit_last(digit_last), .strobe_clock_out(strobe_clock_out),
	.serial_data_out(serial_data_out), .card_present_out_n(card_present_out_n), .busy(busy));

`default_nettype wire
